// ---- slot_irq_consts.vh ----
// Purpose: Offsets, field positions and reset values of the slot interrupt flag block
// Assumes: 16-bit registers on the device's internal register port
// Notes:   Definitions only
`ifndef SLOT_IRQ_CONSTS_VH
`define SLOT_IRQ_CONSTS_VH

// ****************************************************************
// Register offsets
// ****************************************************************
`define BUF_FLAGS_OFFSET        16'h0000
`define DATA_READY_OFFSET       16'h0001
`define LEVEL_ONE_OFFSET        16'h0003
`define AUTOCLEAR_OFFSET        16'h0007
`define PRIMARY_MASK_OFFSET     16'h0014

// ****************************************************************
// Field positions
// ****************************************************************
`define SLOT_COUNT              12
`define BUF_LEVEL_BIT           15
`define BUF_UNDERRUN_BIT        14
`define BUF_OVERRUN_BIT         13
`define SLOT_FIELD_MSB          11
`define SLOT_FIELD_LSB          0

// ****************************************************************
// Reset values and writable bits
// ****************************************************************
`define FLAGS_RESET             16'h0000
`define AUTOCLEAR_RESET         16'h8fff
`define AUTOCLEAR_WMASK         16'h8fff
`define PRIMARY_MASK_RESET      16'h0000
`define PRIMARY_MASK_WMASK      16'hefff
`endif

// ---- flag_bit_array.v ----
// Purpose: Row of sticky status flags with set and clear strobes
// Assumes: Strobes come from logic on clock_i
// Notes:   A set in the same cycle as a clear keeps the flag high
`timescale 1ns/100ps
`default_nettype none
`include "slot_irq_consts.vh"

module flag_bit_array #(
  parameter WIDTH = 12
) (
  input  wire             clock_i,
  input  wire             rst_i,
  input  wire [WIDTH-1:0] set_i,
  input  wire [WIDTH-1:0] clear_i,
  output wire [WIDTH-1:0] flags_o
);

  reg [WIDTH-1:0] flags_reg;

  genvar idx;
  generate
    for (idx = 0; idx < WIDTH; idx = idx + 1)
    begin : g_flag
      always @(posedge clock_i)
      begin
        if (rst_i)
          flags_reg[idx] <= 1'b0;
        else
          flags_reg[idx] <= set_i[idx] | (flags_reg[idx] & ~clear_i[idx]); // R12
      end
    end
  endgenerate

  assign flags_o = flags_reg;

endmodule // flag_bit_array
`default_nettype wire

// ---- irq_router.v ----
// Purpose: Gate flags through routing bits onto one interrupt line
// Assumes: Flags and routing bits share bit positions
// Notes:   Output is registered, one cycle after the flag changes
`timescale 1ns/100ps
`default_nettype none

module irq_router (
  input  wire        clock_i,
  input  wire        rst_i,
  input  wire [15:0] flags_i,
  input  wire [15:0] route_i,
  output wire        irq_o
);

  reg irq_reg;

  always @(posedge clock_i)
  begin
    if (rst_i)
      irq_reg <= 1'b0;
    else
      irq_reg <= |(flags_i & route_i); // R11
  end

  assign irq_o = irq_reg;

endmodule // irq_router
`default_nettype wire

// ---- slot_interrupt_flag_routing.v ----
// Summary of operation
// (R1) Level-one flag per slot set on criterion update
// (R2) Level-one flags reset zero, write-one clears
// (R3) Buffer flag autoclears on buffer read, enable resets one
// (R4) Per-slot autoclear enables clear data flags on read
// (R5) Mask bit 15 routes buffer level flag
// (R6) Mask bit 14 routes underrun flag
// (R7) Mask bit 13 routes overrun flag
// (R8) Mask bits 11 to 0 route slots L-A
// (R9) All routing bits reset to zero
// (R10) Data-ready flag set per new result, W1C
// (R11) Interrupt high while any routed flag high
// (R12) Set beats coincident clear
//
// Purpose: Status flags, autoclear and primary interrupt routing
// Assumes: Register port and event strobes come from logic on clock_i
// Notes:   Read data appears one cycle after reg_rd_i
`timescale 1ns/100ps
`default_nettype none
`include "slot_irq_consts.vh"

module slot_interrupt_flag_routing (
  input  wire        clock_i,
  input  wire        rst_i,
  input  wire [15:0] reg_addr_i,
  input  wire [15:0] reg_wdata_i,
  input  wire        reg_wr_i,
  input  wire        reg_rd_i,
  output reg  [15:0] reg_rdata_o,
  input  wire [11:0] slot_update_i,
  input  wire [11:0] level_one_met_i,
  input  wire [11:0] slot_data_read_i,
  input  wire        buffer_read_i,
  input  wire        buffer_level_event_i,
  input  wire        underrun_event_i,
  input  wire        overrun_event_i,
  output wire        irq_o
);

  // ****************************************************************
  // Control registers
  // ****************************************************************
  reg  [15:0] autoclear_enables_reg;
  reg  [15:0] primary_irq_mask_data_reg;

  wire wr_autoclear = reg_wr_i & (reg_addr_i == `AUTOCLEAR_OFFSET);
  wire wr_mask      = reg_wr_i & (reg_addr_i == `PRIMARY_MASK_OFFSET);
  wire wr_level_one = reg_wr_i & (reg_addr_i == `LEVEL_ONE_OFFSET);
  wire wr_ready     = reg_wr_i & (reg_addr_i == `DATA_READY_OFFSET);
  wire wr_buf       = reg_wr_i & (reg_addr_i == `BUF_FLAGS_OFFSET);

  always @(posedge clock_i)
  begin
    if (rst_i)
    begin
      autoclear_enables_reg     <= `AUTOCLEAR_RESET;    // R3 R4
      primary_irq_mask_data_reg <= `PRIMARY_MASK_RESET; // R9
    end
    else
    begin
      if (wr_autoclear)
        autoclear_enables_reg <= reg_wdata_i & `AUTOCLEAR_WMASK;
      if (wr_mask)
        primary_irq_mask_data_reg <= reg_wdata_i & `PRIMARY_MASK_WMASK;
    end
  end

  wire buffer_level_autoclear_en = autoclear_enables_reg[`BUF_LEVEL_BIT];
  wire [11:0] slot_autoclear_en  = autoclear_enables_reg[`SLOT_FIELD_MSB:`SLOT_FIELD_LSB];

  // ****************************************************************
  // Flag rows
  // ****************************************************************
  wire [11:0] level_one_flags;
  wire [11:0] data_ready_flags;
  wire [2:0]  buf_flags;

  // Criterion only counts while the slot's data registers update
  wire [11:0] level_one_set = slot_update_i & level_one_met_i;       // R1
  wire [11:0] level_one_clr = wr_level_one ? reg_wdata_i[11:0] : 12'h000; // R2
  wire [11:0] ready_clr = (wr_ready ? reg_wdata_i[11:0] : 12'h000)   // R10
                        | (slot_data_read_i & slot_autoclear_en);     // R4
  wire [2:0]  buf_set = {buffer_level_event_i, underrun_event_i, overrun_event_i};
  wire [2:0]  buf_clr = (wr_buf ? reg_wdata_i[15:13] : 3'b000)
                      | {buffer_read_i & buffer_level_autoclear_en, 2'b00}; // R3

  flag_bit_array #(.WIDTH(12)) u_level_one (
    .clock_i (clock_i),
    .rst_i   (rst_i),
    .set_i   (level_one_set),
    .clear_i (level_one_clr),
    .flags_o (level_one_flags)
  );

  flag_bit_array #(.WIDTH(12)) u_data_ready (
    .clock_i (clock_i),
    .rst_i   (rst_i),
    .set_i   (slot_update_i),
    .clear_i (ready_clr),
    .flags_o (data_ready_flags)
  );

  flag_bit_array #(.WIDTH(3)) u_buf_flags (
    .clock_i (clock_i),
    .rst_i   (rst_i),
    .set_i   (buf_set),
    .clear_i (buf_clr),
    .flags_o (buf_flags)
  );

  // ****************************************************************
  // Primary interrupt routing
  // ****************************************************************
  // Bit layout matches the mask: 15 level, 14 underrun, 13 overrun, 11:0 slots
  wire [15:0] routed_flags = {buf_flags, 1'b0, data_ready_flags}; // R5 R6 R7 R8

  irq_router u_router (
    .clock_i (clock_i),
    .rst_i   (rst_i),
    .flags_i (routed_flags),
    .route_i (primary_irq_mask_data_reg),
    .irq_o   (irq_o)
  );

  // ****************************************************************
  // Register read
  // ****************************************************************
  reg [15:0] rdata_next;

  always @*
  begin
    case (reg_addr_i)
      `BUF_FLAGS_OFFSET:    rdata_next = {buf_flags, 13'h0000};
      `DATA_READY_OFFSET:   rdata_next = {4'h0, data_ready_flags};
      `LEVEL_ONE_OFFSET:    rdata_next = {4'h0, level_one_flags};
      `AUTOCLEAR_OFFSET:    rdata_next = autoclear_enables_reg;
      `PRIMARY_MASK_OFFSET: rdata_next = primary_irq_mask_data_reg;
      default:              rdata_next = 16'h0000;
    endcase
  end

  always @(posedge clock_i)
  begin
    if (rst_i)
      reg_rdata_o <= 16'h0000;
    else if (reg_rd_i)
      reg_rdata_o <= rdata_next;
  end

endmodule // slot_interrupt_flag_routing
`default_nettype wire

// ---- host_model.sv ----
// Purpose: Host side of the register port. Assumes: one clock. Notes: bus idles to inverse
`timescale 1ns/100ps
`default_nettype none
module host_model (
  input  wire logic        clock_i,
  output logic      [15:0] addr_o,
  output logic      [15:0] wdata_o,
  output logic             wr_o,
  output logic             rd_o
);
  initial {addr_o, wdata_o, wr_o, rd_o} = 34'h0;
  // One-cycle strobe, then released bus shows the inverse of the last value
  task acc(input logic w, input logic [15:0] a, input logic [15:0] d);
    @(posedge clock_i);
    wr_o <= w;
    rd_o <= !w;
    addr_o <= a;
    wdata_o <= d;
    @(posedge clock_i);
    wr_o <= 1'b0;
    rd_o <= 1'b0;
    addr_o <= ~a;
    wdata_o <= ~d;
  endtask
endmodule // host_model
`default_nettype wire

// ---- slot_irq_monitor.sv ----
// Purpose: Port checks of routing. Assumes: mask tracked from writes. Notes: none
`timescale 1ns/100ps
`default_nettype none
module slot_irq_monitor (
  input wire logic        clock_i, rst_i, reg_wr_i, reg_rd_i, irq_o,
  input wire logic        buffer_level_event_i, underrun_event_i, overrun_event_i,
  input wire logic [15:0] reg_addr_i, reg_wdata_i, reg_rdata_o,
  input wire logic [11:0] slot_update_i
);
  logic [15:0] m;
  wire mw = reg_wr_i && reg_addr_i == 16'h0014;
  always @(posedge clock_i)
    if (rst_i) m <= 16'h0000;
    else if (mw) m <= reg_wdata_i & 16'hefff;
  default clocking @(posedge clock_i); endclocking
  default disable iff (rst_i);
  sequence s_two; ##2 irq_o; endsequence
  property p_lvl; buffer_level_event_i && m[15] && !mw |-> s_two; endproperty
  a_lvl: assert property (p_lvl) else $error("level flag not routed");
  property p_und; underrun_event_i && m[14] && !mw |-> s_two; endproperty
  a_und: assert property (p_und) else $error("underrun not routed");
  property p_ovf; overrun_event_i && m[13] && !mw |-> s_two; endproperty
  a_ovf: assert property (p_ovf) else $error("overrun not routed");
  property p_slot; (slot_update_i & m[11:0]) != 12'h000 && !mw |-> s_two; endproperty
  a_slot: assert property (p_slot) else $error("slot flag not routed");
  property p_mzero; m == 16'h0000 |=> !irq_o; endproperty
  a_mzero: assert property (p_mzero) else $error("irq without routing");
  property p_rst; $fell(rst_i) |-> !irq_o; endproperty
  a_rst: assert property (p_rst) else $error("irq high after reset");
  property p_hold; !reg_rd_i |=> $stable(reg_rdata_o); endproperty
  a_hold: assert property (p_hold) else $error("read data moved");
  property p_unm; reg_rd_i && reg_addr_i == 16'h0002 |=> reg_rdata_o == 16'h0000; endproperty
  a_unm: assert property (p_unm) else $error("unmapped read not zero");
endmodule // slot_irq_monitor
bind slot_interrupt_flag_routing slot_irq_monitor u_mon (.*);
`default_nettype wire

// ---- tb_top.sv ----
// Purpose: Random traffic against a flag model. Assumes: 125 MHz. Notes: LFSR stimulus
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  logic clock_i = 0, rst_i = 1, go = 0, br = 0, bl = 0, un = 0, ov = 0, wr, rd, irq_o, xi;
  logic [11:0] su = 0, lm = 0, sr = 0, dr, l1;
  logic [15:0] addr, wd, rdata, bf, ac, mk, ex;
  logic [31:0] r = 32'd88544;
  logic [15:0] at [6] = '{16'h0000, 16'h0001, 16'h0003, 16'h0007, 16'h0014, 16'h0002};
  int fail_count = 0, comparisons = 0;
  always #4 clock_i = ~clock_i;
  host_model u_host (.clock_i(clock_i), .addr_o(addr), .wdata_o(wd), .wr_o(wr), .rd_o(rd));
  slot_interrupt_flag_routing u_dut (.clock_i(clock_i), .rst_i(rst_i), .reg_addr_i(addr),
    .reg_wdata_i(wd), .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata), .slot_update_i(su),
    .level_one_met_i(lm), .slot_data_read_i(sr), .buffer_read_i(br),
    .buffer_level_event_i(bl), .underrun_event_i(un), .overrun_event_i(ov), .irq_o(irq_o));
  function automatic logic [31:0] nx(input logic [31:0] s);
    nx = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  always @(posedge clock_i)
  begin
    r <= nx(r);
    su <= go ? r[11:0] & r[23:12] : 12'h000;
    lm <= r[27:16];
    sr <= go ? r[15:4] & r[31:20] : 12'h000;
    br <= go & r[0];
    bl <= go & r[1] & r[5];
    un <= go & r[2] & r[7];
    ov <= go & r[3] & r[9];
  end
  always @(posedge clock_i)
    if (rst_i) {bf, dr, l1, ac, mk, ex, xi} <= {40'h0, 16'h8fff, 33'h0};
    else
    begin
      if (rd) ex <= addr == 0 ? bf : addr == 1 ? {4'h0, dr} : addr == 3 ? {4'h0, l1} :
                    addr == 7 ? ac : addr == 20 ? mk : 16'h0000;
      bf <= bf & ~(wr && addr == 0 ? wd & 16'he000 : 16'h0) & ~{br & ac[15], 15'h0}
            | {bl, un, ov, 13'h0};
      dr <= dr & ~(wr && addr == 1 ? wd[11:0] : 12'h0) & ~(sr & ac[11:0]) | su;
      l1 <= l1 & ~(wr && addr == 3 ? wd[11:0] : 12'h0) | su & lm;
      if (wr && addr == 7) ac <= wd & 16'h8fff;
      if (wr && addr == 20) mk <= wd & 16'hefff;
      xi <= |({bf[15:13], 1'b0, dr} & mk[15:0]);
    end
  task chk_rd(input logic [15:0] g, input logic [15:0] e);
    comparisons++;
    if (g !== e) begin fail_count++; $display("[ERR] %0t rdata %h exp %h", $time, g, e); end
  endtask
  task chk_irq(input logic g, input logic e);
    comparisons++;
    if (g !== e) begin fail_count++; $display("[ERR] %0t irq %b exp %b", $time, g, e); end
  endtask
  always @(negedge clock_i)
    if (!rst_i)
    begin
      chk_rd(rdata, ex);
      chk_irq(irq_o, xi);
    end
  task give_verdict;
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial
  begin
    repeat (3000) @(posedge clock_i);
    fail_count++;
    $display("[ERR] %0t watchdog", $time);
    give_verdict;
  end
  initial
  begin
    for (int k = 0; k < 2; k++)
    begin
      repeat (10) @(posedge clock_i);
      rst_i <= 1'b0;
      for (int i = 0; i < 6; i++) u_host.acc(1'b0, at[i], 16'h0000);
      $display("reset values test done");
      go <= 1'b1;
      repeat (600) u_host.acc(r[4], at[r[10:8] % 6], r[31:16]);
      $display("random traffic test done");
      go <= 1'b0;
      rst_i <= 1'b1;
    end
    give_verdict;
  end
endmodule // tb_top
`default_nettype wire
